// ---- rtl/cwd_goertzel.sv ----
`timescale 1ns/1ps
`default_nettype none
module cwd_goertzel (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // converter samples
  input  wire logic        smpValid,
  input  wire logic [9:0]  smp,
  // tone level, one per block
  output logic             ampValid,
  output logic [15:0]      amp
);

  // ****************************************************
  // single-bin filter
  // ****************************************************
  logic signed [23:0] s1_q, s1_d, s2_q, s2_d, s0;
  logic        [5:0]  cnt_q, cnt_d;
  logic               ampValid_q, ampValid_d;
  logic        [15:0] amp_q, amp_d;
  logic        [6:0]  hc_q, hc_d;
  logic signed [10:0] xs;
  logic signed [16:0] coefS;
  logic signed [40:0] fb, fc;
  logic signed [47:0] pwr;

  assign coefS = $signed({1'b0, cwd_pkg::GZ_COEF});

  always_comb begin
    // centre the unsigned converter code
    xs  = $signed({1'b0, smp}) - $signed({1'b0, cwd_pkg::SMP_MID});
    fb  = (s1_q * coefS) >>> cwd_pkg::GZ_FRAC;
    s0  = 24'(xs) + $signed(fb[23:0]) - s2_q;
    fc  = (s0 * coefS) >>> cwd_pkg::GZ_FRAC;
    // power, not magnitude: saves a square root, threshold adapts anyway
    pwr = 48'(s0 * s0) + 48'(s1_q * s1_q) - 48'($signed(fc[23:0]) * s1_q);
    s1_d       = s1_q;
    s2_d       = s2_q;
    cnt_d      = cnt_q;
    ampValid_d = 1'b0;
    amp_d      = amp_q;
    hc_d = ampValid_q ? 7'(smpValid) : hc_q + 7'(smpValid);
    if (smpValid) begin
      if (cnt_q == cwd_pkg::BLK_LEN - 6'h01) begin
        s1_d       = '0;
        s2_d       = '0;
        cnt_d      = '0;
        ampValid_d = 1'b1;
        if (pwr < 0) begin
          amp_d = '0;
        end else if (|pwr[47:cwd_pkg::PWR_LSB+16]) begin
          amp_d = 16'hFFFF;
        end else begin
          amp_d = pwr[cwd_pkg::PWR_LSB +: 16];
        end
      end else begin
        s2_d  = s1_q;
        s1_d  = s0;
        cnt_d = cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1_q       <= '0;
      s2_q       <= '0;
      cnt_q      <= '0;
      ampValid_q <= 1'b0;
      amp_q      <= '0;
      hc_q       <= '0;
    end else begin
      s1_q       <= s1_d;
      s2_q       <= s2_d;
      cnt_q      <= cnt_d;
      ampValid_q <= ampValid_d;
      amp_q      <= amp_d;
      hc_q       <= hc_d;
    end
  end

  assign ampValid = ampValid_q;
  assign amp      = amp_q;

  property p_src;
    @(posedge clk_sys) disable iff (!rst_n)
      ampValid_q |-> $past(smpValid);
  endproperty
  a_src: assert property (p_src)
    else $error("level produced without a sample");

  property p_blk;
    @(posedge clk_sys) disable iff (!rst_n)
      ampValid_q |-> hc_q == 7'h30;
  endproperty
  a_blk: assert property (p_blk)
    else $error("block did not hold 48 samples");

endmodule : cwd_goertzel
`default_nettype wire

// ---- rtl/cwd_pkg.sv ----
`default_nettype none
package cwd_pkg;

  // ****************************************************
  // sampling and tone filter
  // ****************************************************
  // converter rate 12.019 as printed, kept in thousandths
  localparam logic [15:0] RATE_MILLI = 16'h2EF3;
  localparam logic [9:0]  SMP_MID    = 10'h200;
  localparam logic [5:0]  BLK_LEN    = 6'h30;
  localparam logic [7:0]  BW_HZ      = 8'hFA;
  localparam logic [7:0]  MEAS_PER_S = 8'hFA;
  localparam logic [8:0]  BLOCK_MS   = 9'h004;
  // bin coefficient, 2cos(w) in Q14, tuned for a 700 Hz note
  localparam logic [15:0] GZ_COEF    = 16'h778B;
  localparam int          GZ_FRAC    = 14;
  localparam int          PWR_LSB    = 20;

  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_BLANK  = 4'h1;
  localparam logic [3:0]  REG_TIMAVG = 4'h2;
  localparam logic [3:0]  REG_THRAVG = 4'h3;
  localparam logic [3:0]  REG_LEVEL  = 4'h4;
  localparam logic [3:0]  REG_THRESH = 4'h5;
  localparam logic [3:0]  REG_DIT    = 4'h6;
  localparam logic [3:0]  REG_STATUS = 4'h7;
  localparam int          CTRL_RX    = 0;
  localparam int          CTRL_TX    = 1;
  localparam int          CTRL_EDIT  = 2;
  localparam logic [2:0]  CTRL_RST   = 3'h7;
  localparam logic [7:0]  BLANK_RST  = 8'h0A;
  localparam logic [7:0]  TIMAVG_RST = 8'h04;
  localparam logic [7:0]  THRAVG_RST = 8'h10;
  localparam logic [15:0] THR_RST    = 16'h0100;

  // ****************************************************
  // morse timing, dit length in blocks with 4 fraction bits
  // ****************************************************
  localparam logic [15:0] DIT_RST    = 16'h00C0;
  localparam logic [15:0] DIT_MIN    = 16'h0010;
  localparam logic [2:0]  DIT_UNIT   = 3'h1;
  localparam logic [2:0]  DAH_LEN    = 3'h3;
  localparam logic [2:0]  WRD_GAP    = 3'h7;
  localparam logic [2:0]  DAH_CUT    = 3'((DIT_UNIT + DAH_LEN) >> 1);
  // widen before adding: three plus seven does not fit in three bits
  localparam logic [2:0]  WORD_CUT   = 3'((4'(DAH_LEN) + 4'(WRD_GAP)) >> 1);
  localparam logic [7:0]  DAH_INV    = 8'h55;
  localparam logic [2:0]  LEN_MAX    = 3'h6;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_THR  = 2'b01,
    ST_CLS  = 2'b11,
    ST_TIM  = 2'b10
  } cwd_state_t;

  typedef struct packed {
    logic       toEdit;
    logic       isSpace;
    logic [2:0] len;
    logic [5:0] pattern;
  } cwd_char_t;

endpackage : cwd_pkg
`default_nettype wire

// ---- rtl/cwd_tone_decoder.sv ----
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cwd_tone_decoder (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  // converter samples
  input  wire logic                smpValid,
  input  wire logic [9:0]          smp,
  // own keying and editing state
  input  wire logic                txActive,
  input  wire logic                keyDown,
  input  wire logic                editActive,
  // register port
  input  wire logic [3:0]          regAddr,
  input  wire logic [15:0]         regWdata,
  input  wire logic                regWr,
  input  wire logic                regRd,
  output logic [15:0]              regRdata,
  // character stream
  output logic                     chValid,
  input  wire logic                chReady,
  output cwd_pkg::cwd_char_t       chData
);

  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic atLeast(input logic [11:0] n,
                                   input logic [15:0] d,
                                   input logic [2:0]  k);
    atLeast = 19'({n, 4'h0}) >= 19'(d) * 19'(k);
  endfunction : atLeast

  function automatic logic [16:0] absDiff(input logic [15:0] a,
                                          input logic [15:0] b);
    absDiff = (a < b) ? {1'b1, 16'(b - a)} : {1'b0, 16'(a - b)};
  endfunction : absDiff

  // ****************************************************
  // tone filter
  // ****************************************************
  logic        ampValid;
  logic [15:0] ampNew;

  cwd_goertzel u_gz (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .smpValid (smpValid),
    .smp      (smp),
    .ampValid (ampValid),
    .amp      (ampNew)
  );

  // ****************************************************
  // declarations
  // ****************************************************
  logic [2:0]          ctrl_q, ctrl_d;
  logic [7:0]          blank_q, blank_d;
  logic [7:0]          timAvg_q, timAvg_d;
  logic [7:0]          thrAvg_q, thrAvg_d;
  logic [15:0]         rdata_q, rdata_d;
  cwd_pkg::cwd_state_t st_q, st_d;
  logic [15:0]         amp_q, amp_d;
  logic                blkPend_q, blkPend_d;
  logic [15:0]         thr_q, thr_d;
  logic [15:0]         dit_q, dit_d;
  logic [15:0]         rem_q, rem_d;
  logic [15:0]         quo_q, quo_d;
  logic                neg_q, neg_d;
  logic                rawTone_q, rawTone_d;
  logic                decEn_q, decEn_d;
  logic                toEdit_q, toEdit_d;
  logic                tone_q, tone_d;
  logic [7:0]          deb_q, deb_d;
  logic [11:0]         run_q, run_d;
  logic [5:0]          pattern_q, pattern_d;
  logic [2:0]          len_q, len_d;
  logic                charDone_q, charDone_d;
  logic                wordDone_q, wordDone_d;
  cwd_pkg::cwd_char_t  pend_q, pend_d;
  logic                pendValid_q, pendValid_d;
  cwd_pkg::cwd_char_t  buf_q [2];
  cwd_pkg::cwd_char_t  buf_d [2];
  logic [1:0]          bufCnt_q, bufCnt_d;
  logic [1:0]          wIdx;
  logic                bufIn;
  logic                pop;
  logic [15:0]         divisor;
  logic [7:0]          bbC;
  logic                toggle;
  logic                symEnd;
  logic                isDah;
  logic                charHit;
  logic                wordHit;
  logic [15:0]         durQ;
  logic [23:0]         mult;
  logic [15:0]         meas;
  logic [16:0]         adS;
  logic [16:0]         adT;

  // ****************************************************
  // register port
  // ****************************************************
  always_comb begin
    ctrl_d   = ctrl_q;
    blank_d  = blank_q;
    timAvg_d = timAvg_q;
    thrAvg_d = thrAvg_q;
    rdata_d  = '0;
    if (regWr) begin
      case (regAddr)
        cwd_pkg::REG_CTRL:   ctrl_d   = regWdata[2:0];
        cwd_pkg::REG_BLANK:  blank_d  = regWdata[7:0];
        cwd_pkg::REG_TIMAVG: timAvg_d = regWdata[7:0];
        cwd_pkg::REG_THRAVG: thrAvg_d = regWdata[7:0];
        default:             ctrl_d   = ctrl_q;
      endcase
    end
    if (regRd) begin
      case (regAddr)
        cwd_pkg::REG_CTRL:   rdata_d = {13'h0000, ctrl_q};
        cwd_pkg::REG_BLANK:  rdata_d = {8'h00, blank_q};
        cwd_pkg::REG_TIMAVG: rdata_d = {8'h00, timAvg_q};
        cwd_pkg::REG_THRAVG: rdata_d = {8'h00, thrAvg_q};
        cwd_pkg::REG_LEVEL:  rdata_d = amp_q;
        cwd_pkg::REG_THRESH: rdata_d = thr_q;
        cwd_pkg::REG_DIT:    rdata_d = dit_q;
        cwd_pkg::REG_STATUS: rdata_d = {11'h000, bufCnt_q, pendValid_q,
                                        tone_q, decEn_q};
        default:             rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_q   <= cwd_pkg::CTRL_RST;
      blank_q  <= cwd_pkg::BLANK_RST;
      timAvg_q <= cwd_pkg::TIMAVG_RST;
      thrAvg_q <= cwd_pkg::THRAVG_RST;
      rdata_q  <= '0;
    end else begin
      ctrl_q   <= ctrl_d;
      blank_q  <= blank_d;
      timAvg_q <= timAvg_d;
      thrAvg_q <= thrAvg_d;
      rdata_q  <= rdata_d;
    end
  end

  // ****************************************************
  // decoder
  // ****************************************************
  // one block is fully handled long before the next arrives, so the
  // moving averages divide by repeated subtraction instead of a divider
  always_comb begin
    divisor = {8'h00, (st_q == cwd_pkg::ST_TIM) ? timAvg_q : thrAvg_q};
    if (divisor == '0) begin
      divisor = 16'h0001;
    end
    // blanking time in blocks, rounded up, never zero
    bbC = 8'((9'(blank_q) + cwd_pkg::BLOCK_MS - 9'h001) / cwd_pkg::BLOCK_MS);
    if (bbC == '0) begin
      bbC = 8'h01;
    end
    toggle  = (rawTone_q != tone_q) && ((9'(deb_q) + 9'h001) >= 9'(bbC));
    symEnd  = toggle && tone_q;
    isDah   = atLeast(run_q, dit_q, cwd_pkg::DAH_CUT);
    charHit = !tone_q && !toggle && (len_q != '0) && !charDone_q
              && atLeast(run_q, dit_q, cwd_pkg::DAH_CUT);
    wordHit = !tone_q && !toggle && charDone_q && !wordDone_q
              && atLeast(run_q, dit_q, cwd_pkg::WORD_CUT);
    durQ    = {run_q, 4'h0};
    mult    = {8'h00, durQ} * {16'h0000, cwd_pkg::DAH_INV};
    meas    = isDah ? mult[23:8] : durQ;
    adS     = absDiff(meas, dit_q);
    adT     = absDiff(amp_q, thr_q);
    st_d        = st_q;
    amp_d       = amp_q;
    blkPend_d   = blkPend_q;
    thr_d       = thr_q;
    dit_d       = dit_q;
    rem_d       = rem_q;
    quo_d       = quo_q;
    neg_d       = neg_q;
    rawTone_d   = rawTone_q;
    decEn_d     = decEn_q;
    toEdit_d    = toEdit_q;
    tone_d      = tone_q;
    deb_d       = deb_q;
    run_d       = run_q;
    pattern_d   = pattern_q;
    len_d       = len_q;
    charDone_d  = charDone_q;
    wordDone_d  = wordDone_q;
    pend_d      = pend_q;
    pendValid_d = pendValid_q && !bufIn;
    unique case (st_q)
      cwd_pkg::ST_IDLE: begin
        // a held character stalls decoding, so a full buffer drops blocks but never a character
        if (blkPend_q && !pendValid_q) begin
          blkPend_d = 1'b0;
          rem_d     = adT[15:0];
          neg_d     = adT[16];
          quo_d     = '0;
          rawTone_d = txActive ? keyDown : (amp_q > thr_q);
          decEn_d   = txActive ? ctrl_q[cwd_pkg::CTRL_TX]
                               : ctrl_q[cwd_pkg::CTRL_RX];
          toEdit_d  = editActive && ctrl_q[cwd_pkg::CTRL_EDIT];
          st_d      = cwd_pkg::ST_THR;
        end
      end
      cwd_pkg::ST_THR, cwd_pkg::ST_TIM: begin
        if (rem_q >= divisor) begin
          rem_d = rem_q - divisor;
          quo_d = quo_q + 16'h0001;
        end else if (st_q == cwd_pkg::ST_THR) begin
          thr_d = neg_q ? thr_q - quo_q : thr_q + quo_q;
          st_d  = cwd_pkg::ST_CLS;
        end else begin
          dit_d = neg_q ? dit_q - quo_q : dit_q + quo_q;
          if (dit_d < cwd_pkg::DIT_MIN) begin
            dit_d = cwd_pkg::DIT_MIN;
          end
          st_d = cwd_pkg::ST_IDLE;
        end
      end
      cwd_pkg::ST_CLS: begin
        st_d = cwd_pkg::ST_IDLE;
        if (toggle) begin
          tone_d = rawTone_q;
          deb_d  = '0;
          run_d  = {4'h0, bbC};
          if (symEnd) begin
            charDone_d = 1'b0;
            wordDone_d = 1'b0;
            pattern_d  = {pattern_q[4:0], isDah};
            len_d      = (len_q == cwd_pkg::LEN_MAX) ? cwd_pkg::LEN_MAX
                                                     : len_q + 3'h1;
            rem_d      = adS[15:0];
            neg_d      = adS[16];
            quo_d      = '0;
            st_d       = cwd_pkg::ST_TIM;
          end
        end else begin
          deb_d = (rawTone_q != tone_q) ? deb_q + 8'h01 : 8'h00;
          run_d = (run_q == 12'hFFF) ? run_q : run_q + 12'h001;
        end
        if (charHit) begin
          charDone_d  = 1'b1;
          pattern_d   = '0;
          len_d       = '0;
          pendValid_d = decEn_q;
          pend_d      = '{toEdit: toEdit_q, isSpace: 1'b0,
                          len: len_q, pattern: pattern_q};
        end
        if (wordHit) begin
          wordDone_d  = 1'b1;
          pendValid_d = decEn_q;
          pend_d      = '{toEdit: toEdit_q, isSpace: 1'b1,
                          len: 3'h0, pattern: 6'h00};
        end
        if (!decEn_q) begin
          pattern_d = '0;
          len_d     = '0;
        end
      end
    endcase
    if (ampValid) begin
      blkPend_d = 1'b1;
      amp_d     = ampNew;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q        <= cwd_pkg::ST_IDLE;
      amp_q       <= '0;
      blkPend_q   <= 1'b0;
      thr_q       <= cwd_pkg::THR_RST;
      dit_q       <= cwd_pkg::DIT_RST;
      rem_q       <= '0;
      quo_q       <= '0;
      neg_q       <= 1'b0;
      rawTone_q   <= 1'b0;
      decEn_q     <= 1'b0;
      toEdit_q    <= 1'b0;
      tone_q      <= 1'b0;
      deb_q       <= '0;
      run_q       <= '0;
      pattern_q   <= '0;
      len_q       <= '0;
      charDone_q  <= 1'b1;
      wordDone_q  <= 1'b1;
      pend_q      <= '0;
      pendValid_q <= 1'b0;
    end else begin
      st_q        <= st_d;
      amp_q       <= amp_d;
      blkPend_q   <= blkPend_d;
      thr_q       <= thr_d;
      dit_q       <= dit_d;
      rem_q       <= rem_d;
      quo_q       <= quo_d;
      neg_q       <= neg_d;
      rawTone_q   <= rawTone_d;
      decEn_q     <= decEn_d;
      toEdit_q    <= toEdit_d;
      tone_q      <= tone_d;
      deb_q       <= deb_d;
      run_q       <= run_d;
      pattern_q   <= pattern_d;
      len_q       <= len_d;
      charDone_q  <= charDone_d;
      wordDone_q  <= wordDone_d;
      pend_q      <= pend_d;
      pendValid_q <= pendValid_d;
    end
  end

  // ****************************************************
  // two-entry output buffer, head always in slot 0
  // ****************************************************
  assign pop   = chValid && chReady;
  // ready ignores a same-cycle pop: costs a cycle, keeps paths short
  assign bufIn = pendValid_q && (bufCnt_q != 2'h2);
  assign wIdx  = bufCnt_q - {1'b0, pop};

  always_comb begin
    buf_d    = buf_q;
    bufCnt_d = bufCnt_q + {1'b0, bufIn} - {1'b0, pop};
    if (pop) begin
      buf_d[0] = buf_q[1];
    end
    if (bufIn) begin
      buf_d[wIdx[0]] = pend_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      buf_q    <= '{default: '0};
      bufCnt_q <= '0;
    end else begin
      buf_q    <= buf_d;
      bufCnt_q <= bufCnt_d;
    end
  end

  assign chValid  = (bufCnt_q != 2'h0);
  assign chData   = buf_q[0];
  assign regRdata = rdata_q;

  // ****************************************************
  // checks
  // ****************************************************
  property p_cad;
    @(posedge clk_sys) disable iff (!rst_n)
      ampValid |=> blkPend_q && (amp_q == $past(ampNew));
  endproperty
  a_cad: assert property (p_cad)
    else $error("block level not handed to the decoder");

  property p_tone;
    @(posedge clk_sys) disable iff (!rst_n)
      (st_q == cwd_pkg::ST_IDLE && blkPend_q && !pendValid_q && !txActive)
      |=> rawTone_q == $past(amp_q > thr_q);
  endproperty
  a_tone: assert property (p_tone)
    else $error("tone decision disagrees with threshold");

  property p_blank;
    @(posedge clk_sys) disable iff (!rst_n)
      $changed(tone_q) |-> 9'($past(deb_q)) + 9'h001 >= 9'($past(bbC));
  endproperty
  a_blank: assert property (p_blank)
    else $error("tone state changed before the blanking time");

  property p_dah;
    @(posedge clk_sys) disable iff (!rst_n)
      (st_q == cwd_pkg::ST_CLS && symEnd && decEn_q)
      |=> pattern_q[0] == $past(atLeast(run_q, dit_q, cwd_pkg::DAH_CUT));
  endproperty
  a_dah: assert property (p_dah)
    else $error("burst sorted wrongly into dit or dah");

  property p_dit;
    @(posedge clk_sys) disable iff (!rst_n)
      (st_q == cwd_pkg::ST_TIM && rem_q < divisor)
      |=> st_q == cwd_pkg::ST_IDLE && dit_q >= cwd_pkg::DIT_MIN
          && ($past(neg_q) ? dit_q <= $past(dit_q) : dit_q >= $past(dit_q));
  endproperty
  a_dit: assert property (p_dit)
    else $error("timing average moved the wrong way");

  property p_thr;
    @(posedge clk_sys) disable iff (!rst_n)
      (st_q == cwd_pkg::ST_THR && rem_q < divisor)
      |=> st_q == cwd_pkg::ST_CLS
          && ($past(neg_q) ? thr_q <= $past(thr_q) : thr_q >= $past(thr_q));
  endproperty
  a_thr: assert property (p_thr)
    else $error("threshold average moved the wrong way");

  property p_off;
    @(posedge clk_sys) disable iff (!rst_n)
      (st_q == cwd_pkg::ST_CLS && !decEn_q) |=> !pendValid_q && len_q == 3'h0;
  endproperty
  a_off: assert property (p_off)
    else $error("character produced with decoding disabled");

  property p_txsel;
    @(posedge clk_sys) disable iff (!rst_n)
      (st_q == cwd_pkg::ST_IDLE && blkPend_q && !pendValid_q && txActive)
      |=> rawTone_q == $past(keyDown)
          && decEn_q == $past(ctrl_q[cwd_pkg::CTRL_TX]);
  endproperty
  a_txsel: assert property (p_txsel)
    else $error("own keying not used while transmitting");

  property p_edit;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(pendValid_q) |-> pend_q.toEdit == toEdit_q;
  endproperty
  a_edit: assert property (p_edit)
    else $error("edit flag of character is wrong");

  property p_word;
    @(posedge clk_sys) disable iff (!rst_n)
      ($rose(pendValid_q) && pend_q.isSpace)
      |-> $past(atLeast(run_q, dit_q, cwd_pkg::WORD_CUT));
  endproperty
  a_word: assert property (p_word)
    else $error("word space before five dit lengths");

  property p_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      (chValid && !chReady) |=> chValid && $stable(chData);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stalled character lost or changed");

endmodule : cwd_tone_decoder
`default_nettype wire

// ---- testbench/cwd_adc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cwd_adc_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // tone request from the bench
  input  wire logic       toneOn,
  // converter samples
  output logic            smpValid,
  output logic [9:0]      smp
);
  logic [2:0] divCnt_q;
  logic [3:0] phase_q;
  // one 10-bit code every 6 cycles
  // square note of 16 codes a period, close to the filter bin, so a
  // tone gives a clear level and silence gives none
  always_ff @(posedge clk_sys) begin
    if (!rst_n || divCnt_q == 3'h5) begin
      divCnt_q <= 3'h0;
    end else begin
      divCnt_q <= divCnt_q + 3'h1;
    end
    if (!rst_n) begin
      phase_q <= 4'h0;
    end else if (divCnt_q == 3'h5) begin
      phase_q <= phase_q + 4'h1;
    end
    smpValid <= rst_n && (divCnt_q == 3'h5);
    smp      <= toneOn ? (phase_q[3] ? 10'h3FF : 10'h000) : 10'h200;
  end
endmodule : cwd_adc_model
`default_nettype wire

// ---- testbench/cwd_tone_decoder_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module cwd_tone_decoder_tb_top;
  logic                clk_sys   = 1'b0;
  logic                rst_n     = 1'b0;
  logic                smpValid;
  logic [9:0]          smp;
  logic                txActive  = 1'b1;
  logic                keyDown   = 1'b0;
  logic                editActive = 1'b0;
  logic [3:0]          regAddr   = 4'h0;
  logic [15:0]         regWdata  = 16'h0000;
  logic                regWr     = 1'b0;
  logic                regRd     = 1'b0;
  logic [15:0]         regRdata;
  logic                chValid;
  logic                chReady   = 1'b0;
  cwd_pkg::cwd_char_t  chData;
  int                  fails     = 0;
  int                  numChecks = 0;

  always #12.5 clk_sys = !clk_sys;

  cwd_adc_model i_adc (.clk_sys(clk_sys), .rst_n(rst_n), .toneOn(keyDown),
    .smpValid(smpValid), .smp(smp));
  cwd_tone_decoder i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .smpValid(smpValid), .smp(smp), .txActive(txActive), .keyDown(keyDown),
    .editActive(editActive), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .chValid(chValid),
    .chReady(chReady), .chData(chData));

  // ****************************************************
  // shared tasks
  // ****************************************************
  task automatic wrap_up();
    if (fails == 0 && numChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic check(input string nm, input logic [15:0] seen, exp);
    numChecks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk_sys);
    regWr    <= 1'b0;
  endtask : regWrite

  // read data stand only in the cycle after the strobe
  task automatic regCheck(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk_sys);
    regRd   <= 1'b0;
    #1 check("regRdata", regRdata, exp);
  endtask : regCheck

  // one block is 48 samples of 6 cycles
  task automatic key(input logic on, input int nBlk);
    @(posedge clk_sys);
    keyDown <= on;
    repeat (nBlk * 288) @(posedge clk_sys);
  endtask : key

  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic scnRegs();
    regCheck(cwd_pkg::REG_CTRL, 16'h0007);
    regCheck(cwd_pkg::REG_BLANK, 16'h000A);
    regCheck(cwd_pkg::REG_TIMAVG, 16'h0004);
    regCheck(cwd_pkg::REG_THRAVG, 16'h0010);
    regCheck(cwd_pkg::REG_THRESH, 16'h0100);
    regCheck(cwd_pkg::REG_DIT, 16'h00C0);
    regCheck(4'h9, 16'h0000);
    regWrite(cwd_pkg::REG_BLANK, 16'h0004);
    regCheck(cwd_pkg::REG_BLANK, 16'h0004);
  endtask : scnRegs

  // dit then dah while editing; receiver stalls so the character and the word space queue
  task automatic scnCharA();
    int i;
    @(posedge clk_sys);
    editActive <= 1'b1;
    key(1'b1, 12);
    key(1'b0, 12);
    key(1'b1, 36);
    key(1'b0, 0);
    for (i = 0; i < 40000 && chValid !== 1'b1; i++) @(posedge clk_sys);
    check("chValid", {15'h0000, chValid}, 16'h0001);
    if (chValid !== 1'b1) wrap_up();
    check("chData", {5'h00, chData}, 16'h0481);
    key(1'b0, 45);
    check("chData", {5'h00, chData}, 16'h0481);
    chReady <= 1'b1;
    @(posedge clk_sys);
    chReady <= 1'b0;
    #1 check("space", {6'h00, chData[9:0]}, 16'h0200);
    @(posedge clk_sys);
    chReady <= 1'b1;
    @(posedge clk_sys);
    chReady <= 1'b0;
    #1 check("chValid", {15'h0000, chValid}, 16'h0000);
  endtask : scnCharA

  // received dit decided on level against the adaptive threshold
  task automatic scnRx();
    @(posedge clk_sys);
    txActive   <= 1'b0;
    editActive <= 1'b0;
    key(1'b1, 6);
    regCheck(cwd_pkg::REG_STATUS, 16'h0003);
    key(1'b1, 6);
    key(1'b0, 45);
    check("rxValid", {15'h0000, chValid}, 16'h0001);
    check("rxChar", {5'h00, chData}, 16'h0040);
    chReady <= 1'b1;
    @(posedge clk_sys);
    chReady <= 1'b0;
    #1 check("rxValid", {15'h0000, chValid}, 16'h0000);
  endtask : scnRx

  task automatic scnDisabled();
    int seen;
    seen = 0;
    regWrite(cwd_pkg::REG_CTRL, 16'h0000);
    chReady <= 1'b1;
    key(1'b1, 12);
    @(posedge clk_sys);
    keyDown <= 1'b0;
    repeat (45 * 288) begin
      @(posedge clk_sys);
      if (chValid !== 1'b0) seen++;
    end
    check("chValidOff", seen[15:0], 16'h0000);
  endtask : scnDisabled

  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    scnRegs();
    scnCharA();
    scnRx();
    scnDisabled();
    wrap_up();
  end
endmodule : cwd_tone_decoder_tb_top
`default_nettype wire
